// ---- hw/pmsc_top.sv ----
`timescale 1ns/1ps
// Functional notes
// R01 - Answer own strapped address 1..7 and broadcast address 0 by default.
// R02 - Broadcast address 0 accepted for read or write.
// R03 - Strap or 16h bit 9 disables broadcast; 0 becomes unique.
// R04 - Unique address 0..7 taken from three straps at reset.
// R05 - Controller keeps management clock at or below 10 MHz.
// R06 - Frame: 32 ones, 01, opcode, 00AAA address, register address.
// R07 - Turnaround Z0 on read, 10 on write; 16 data bits; idle Z.
// R08 - Decode 32 register addresses; unmapped read as zero.
// R09 - Interrupt register bits 15:8 enable conditions onto the pin.
// R10 - Interrupt register bits 7:0 record occurred conditions.
// R11 - Reading interrupt register clears all status bits.
// R12 - 1Fh bit 9 sets pin polarity; active low after reset.
// R13 - Automatic crossover on after reset; 1Fh bit 13 disables it.
// R14 - With crossover off, 1Fh bit 14 forces straight or crossed.
// R15 - With crossover on, follow pairs the partner uses.
// R16 - Local loopback returns MAC frames to MAC, full duplex only.
// R17 - Loopback frames also go to copper except reduced-pin variant.
// R18 - Register 0h bits 14,13,12,8 configure local loopback.
// R19 - Unaddressed frames ignored, data line left undriven.
// R20 - On reads drive only second turnaround bit and data bits.
module pmsc_top (
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_ARST_N,
  input  wire logic                   I_MGMT_CLK,
  input  wire logic                   I_MGMT_DATA,
  output logic                        O_MGMT_DATA,
  output logic                        O_MGMT_DATA_OE,
  input  wire logic [2:0]             I_UNIQUE_ADDRESS_STRAPS,
  input  wire logic                   I_BROADCAST_DISABLE_STRAP,
  input  wire logic                   I_REDUCED_PIN_STRAP,
  input  wire logic [7:0]             I_IRQ_EVENTS,
  output logic                        O_STATUS_CHANGE_IRQ_PIN,
  input  wire logic                   I_PARTNER_ON_OUR_TX,
  output logic                        O_CROSSED_PAIRS,
  input  wire pmsc_pkg::pmsc_mii_type I_MAC_TX,
  input  wire pmsc_pkg::pmsc_mii_type I_LINE_RX,
  output pmsc_pkg::pmsc_mii_type      O_MAC_RX,
  output pmsc_pkg::pmsc_mii_type      O_LINE_TX,
  output logic                        O_SPEED_100,
  output logic                        O_LOOPBACK_ACTIVE
);

  // Pin synchronisation
  logic [7:0]                 sync_s;
  logic                       mdc_s;
  logic                       mdio_s;
  logic                       partner_s;
  pmsc_pkg::pmsc_strap_type   strap_s;

  pmsc_sync #(
    .W        (8)
  ) pmsc_sync_i (
    .i_clk    (I_CORE_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  ({I_MGMT_CLK, I_MGMT_DATA, I_PARTNER_ON_OUR_TX,
                I_BROADCAST_DISABLE_STRAP, I_REDUCED_PIN_STRAP,
                I_UNIQUE_ADDRESS_STRAPS}),
    .o_sync   (sync_s)
  );

  assign mdc_s     = sync_s[7];
  assign mdio_s    = sync_s[6];
  assign partner_s = sync_s[5];
  assign strap_s   = sync_s[4:0];

  // Strap capture after reset release
  // Straps are sampled in the first three cycles after reset; later pin moves are ignored
  logic [1:0]                 settle_q;
  pmsc_pkg::pmsc_strap_type   strap_q;

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      settle_q <= 2'h0;
      strap_q  <= '0;
    end else if (settle_q != pmsc_pkg::STRAP_SETTLE) begin
      settle_q <= settle_q + 2'h1;
      strap_q  <= strap_s;                                  // see R04
    end
  end

  // Management clock edge; data is sampled and launched on the rise
  // Reset value matches the idle-low clock, so reset gives no false edge
  logic                       mdc_prev_q;
  logic                       rise;

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end

  assign rise = mdc_s & ~mdc_prev_q;

  // Registers
  logic [15:0]                basic_q;
  logic [15:0]                ctrl1_q;
  logic [15:0]                ctrl2_q;
  logic [7:0]                 irq_en_q;
  logic [7:0]                 irq_flag_q;

  // Frame engine state
  pmsc_pkg::pmsc_state_type   state_q;
  logic [5:0]                 cnt_q;
  logic [15:0]                shreg_q;
  logic [4:0]                 reg_q;
  logic                       wr_q;

  logic [11:0]                hdr;
  logic [1:0]                 hdr_op;
  logic [4:0]                 hdr_phy;
  logic                       op_ok;
  logic                       bcast_en;
  logic                       addr_hit;
  logic                       hit;
  logic                       hdr_end;
  logic                       ta_end;
  logic                       data_end;
  logic                       rd_fire;
  logic                       wr_fire;
  logic [15:0]                wdata;
  logic [15:0]                rd_data;

  assign hdr      = {shreg_q[10:0], mdio_s};
  assign hdr_op   = hdr[11:10];
  assign hdr_phy  = hdr[9:5];
  assign op_ok    = (hdr_op == pmsc_pkg::OP_READ) ||
                    (hdr_op == pmsc_pkg::OP_WRITE);          // see R06
  assign bcast_en = ~(strap_q.bcast_off |
                      ctrl1_q[pmsc_pkg::CTRL1_BCAST_OFF]);   // see R03
  assign addr_hit = (hdr_phy[2:0] == strap_q.addr) ||
                    (bcast_en &&
                     hdr_phy[2:0] == pmsc_pkg::BCAST_ADDR);  // see R01, R02
  assign hit      = op_ok && addr_hit &&
                    (hdr_phy[4:3] == pmsc_pkg::PHY_HIGH_ZERO);
  assign hdr_end  = rise && state_q == pmsc_pkg::ST_HDR &&
                    cnt_q == pmsc_pkg::HDR_LAST;
  assign ta_end   = rise && state_q == pmsc_pkg::ST_TA &&
                    cnt_q == pmsc_pkg::TA_LAST;
  assign data_end = rise && state_q == pmsc_pkg::ST_DATA &&
                    cnt_q == pmsc_pkg::DATA_LAST;
  assign rd_fire  = ta_end && !wr_q;
  assign wr_fire  = data_end && wr_q;
  assign wdata    = {shreg_q[14:0], mdio_s};

  // Frame sequencing
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= pmsc_pkg::ST_PRE;
      cnt_q   <= 6'h00;
    end else if (rise) begin
      unique case (state_q)
        // Count saturates, so a preamble longer than 32 ones is fine
        pmsc_pkg::ST_PRE: begin                             // see R06
          if (mdio_s) begin
            if (cnt_q != pmsc_pkg::PREAMBLE_ONES) begin
              cnt_q <= cnt_q + 6'h01;
            end
          end else if (cnt_q == pmsc_pkg::PREAMBLE_ONES) begin
            state_q <= pmsc_pkg::ST_START;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        pmsc_pkg::ST_START: begin
          cnt_q   <= 6'h00;
          state_q <= mdio_s ? pmsc_pkg::ST_HDR : pmsc_pkg::ST_PRE;
        end
        pmsc_pkg::ST_HDR: begin
          cnt_q <= cnt_q + 6'h01;
          if (hdr_end) begin
            cnt_q   <= 6'h00;
            // Foreign frames are dropped before turnaround
            state_q <= hit ? pmsc_pkg::ST_TA : pmsc_pkg::ST_PRE; // see R19
          end
        end
        pmsc_pkg::ST_TA: begin
          cnt_q <= cnt_q + 6'h01;
          if (ta_end) begin
            cnt_q   <= 6'h00;
            state_q <= pmsc_pkg::ST_DATA;
          end
        end
        pmsc_pkg::ST_DATA: begin
          cnt_q <= cnt_q + 6'h01;
          if (data_end) begin
            cnt_q   <= 6'h00;
            state_q <= pmsc_pkg::ST_PRE;                    // see R07
          end
        end
      endcase
    end
  end

  // Header capture and data shifting
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shreg_q <= 16'h0000;
      reg_q   <= 5'h00;
      wr_q    <= 1'b0;
    end else if (hdr_end) begin
      reg_q   <= hdr[4:0];
      wr_q    <= (hdr_op == pmsc_pkg::OP_WRITE);
    end else if (rd_fire) begin
      shreg_q <= {rd_data[14:0], 1'b0};
    end else if (rise) begin
      shreg_q <= wdata;
    end
  end

  // Data line drive: Z on first turnaround bit, 0 on second, then data
  // Each bit is launched after a rise and stands for a whole clock period
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_MGMT_DATA    <= 1'b0;
      O_MGMT_DATA_OE <= 1'b0;
    end else if (rise) begin
      if (state_q == pmsc_pkg::ST_TA && cnt_q == 6'h00 && !wr_q) begin
        O_MGMT_DATA    <= 1'b0;                             // see R20
        O_MGMT_DATA_OE <= 1'b1;
      end else if (rd_fire) begin
        O_MGMT_DATA    <= rd_data[15];
      end else if (state_q == pmsc_pkg::ST_DATA && !wr_q &&
                   !data_end) begin
        O_MGMT_DATA    <= shreg_q[15];
      end else begin
        O_MGMT_DATA    <= 1'b0;
        O_MGMT_DATA_OE <= 1'b0;                             // see R07, R20
      end
    end
  end

  // Register read selection over the 32-entry space
  assign rd_data = (reg_q == pmsc_pkg::REG_BASIC) ? basic_q :
                   (reg_q == pmsc_pkg::REG_CTRL1) ? ctrl1_q :
                   (reg_q == pmsc_pkg::REG_IRQ)   ? {irq_en_q, irq_flag_q} :
                   (reg_q == pmsc_pkg::REG_CTRL2) ? ctrl2_q :
                   pmsc_pkg::READ_UNMAPPED;                 // see R08

  logic                       wr_basic;
  logic                       wr_ctrl1;
  logic                       wr_irq;
  logic                       wr_ctrl2;
  logic                       irq_clear;
  logic [7:0]                 irq_flag_d;

  assign wr_basic  = wr_fire && reg_q == pmsc_pkg::REG_BASIC;  // see R18
  assign wr_ctrl1  = wr_fire && reg_q == pmsc_pkg::REG_CTRL1;
  assign wr_irq    = wr_fire && reg_q == pmsc_pkg::REG_IRQ;
  assign wr_ctrl2  = wr_fire && reg_q == pmsc_pkg::REG_CTRL2;
  assign irq_clear = rd_fire && reg_q == pmsc_pkg::REG_IRQ;    // see R11

  // A new event in the clearing cycle survives the clear
  assign irq_flag_d = (irq_clear ? 8'h00 : irq_flag_q) |
                      I_IRQ_EVENTS;                            // see R10

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      basic_q <= pmsc_pkg::BASIC_RST;
      ctrl1_q <= pmsc_pkg::CTRL1_RST;
      ctrl2_q <= pmsc_pkg::CTRL2_RST;
    end else begin
      if (wr_basic) begin
        basic_q <= wdata;
      end
      if (wr_ctrl1) begin
        ctrl1_q <= wdata;
      end
      if (wr_ctrl2) begin
        ctrl2_q <= wdata;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_en_q   <= pmsc_pkg::IRQ_EN_RST;
      irq_flag_q <= pmsc_pkg::IRQ_FLAG_RST;
    end else begin
      irq_flag_q <= irq_flag_d;
      if (wr_irq) begin
        irq_en_q <= wdata[15:8];                            // see R09
      end
    end
  end

  // Interrupt pin with selectable polarity
  // Pin is registered, so a polarity write cannot glitch it
  logic                       irq_any;
  logic                       irq_pin_d;

  assign irq_any   = |(irq_flag_q & irq_en_q);              // see R09
  assign irq_pin_d = ctrl2_q[pmsc_pkg::CTRL2_IRQ_HIGH] ? irq_any
                                                       : ~irq_any; // see R12

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_STATUS_CHANGE_IRQ_PIN <= pmsc_pkg::IRQ_PIN_RST;
    end else begin
      O_STATUS_CHANGE_IRQ_PIN <= irq_pin_d;
    end
  end

  // Automatic crossover
  pmsc_crossover pmsc_crossover_i (
    .i_clk               (I_CORE_CLK),
    .i_arst_n            (I_ARST_N),
    .i_auto_en           (~ctrl2_q[pmsc_pkg::CTRL2_AUTOX_OFF]), // see R13
    .i_force_crossed     (ctrl2_q[pmsc_pkg::CTRL2_FORCE_CROSS]),
    .i_partner_on_our_tx (partner_s),
    .o_crossed           (O_CROSSED_PAIRS)
  );

  // Local loopback; half duplex or autonegotiation keeps it off
  logic                       lb_active;
  pmsc_pkg::pmsc_mii_type     line_tx_d;

  assign lb_active = basic_q[pmsc_pkg::BASIC_LOOPBACK] &
                     basic_q[pmsc_pkg::BASIC_FULL_DUPLEX] &
                     ~basic_q[pmsc_pkg::BASIC_ANEG_EN];     // see R16, R18
  // Reduced-pin variant keeps the copper side quiet in loopback
  assign line_tx_d = (lb_active && strap_q.reduced_pins) ? '0
                                                         : I_MAC_TX; // see R17

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_MAC_RX          <= '0;
      O_LINE_TX         <= '0;
      O_SPEED_100       <= 1'b0;
      O_LOOPBACK_ACTIVE <= 1'b0;
    end else begin
      O_MAC_RX          <= lb_active ? I_MAC_TX : I_LINE_RX; // see R16
      O_LINE_TX         <= line_tx_d;
      O_SPEED_100       <= basic_q[pmsc_pkg::BASIC_SPEED_100]; // see R18
      O_LOOPBACK_ACTIVE <= lb_active;
    end
  end

endmodule

// ---- hw/pmsc_pkg.sv ----
package pmsc_pkg;

  // Register indices on the serial management port
  localparam logic [4:0]  REG_BASIC         = 5'h00;
  localparam logic [4:0]  REG_CTRL1         = 5'h16;
  localparam logic [4:0]  REG_IRQ           = 5'h1B;
  localparam logic [4:0]  REG_CTRL2         = 5'h1F;

  // Field positions
  localparam int          BASIC_LOOPBACK    = 14;
  localparam int          BASIC_SPEED_100   = 13;
  localparam int          BASIC_ANEG_EN     = 12;
  localparam int          BASIC_FULL_DUPLEX = 8;
  localparam int          CTRL1_BCAST_OFF   = 9;
  localparam int          CTRL2_FORCE_CROSS = 14;
  localparam int          CTRL2_AUTOX_OFF   = 13;
  localparam int          CTRL2_IRQ_HIGH    = 9;

  // Reset values
  localparam logic [15:0] BASIC_RST         = 16'h3100;
  localparam logic [15:0] CTRL1_RST         = 16'h0000;
  localparam logic [15:0] CTRL2_RST         = 16'h0000;
  localparam logic [7:0]  IRQ_EN_RST        = 8'h00;
  localparam logic [7:0]  IRQ_FLAG_RST      = 8'h00;
  localparam logic        IRQ_PIN_RST       = 1'b1;
  localparam logic [15:0] READ_UNMAPPED     = 16'h0000;

  // Frame layout
  localparam logic [1:0]  OP_READ           = 2'h2;
  localparam logic [1:0]  OP_WRITE          = 2'h1;
  localparam logic [1:0]  PHY_HIGH_ZERO     = 2'h0;
  localparam logic [2:0]  BCAST_ADDR        = 3'h0;
  localparam logic [5:0]  PREAMBLE_ONES     = 6'h20;
  localparam logic [5:0]  HDR_LAST          = 6'h0B;
  localparam logic [5:0]  TA_LAST           = 6'h01;
  localparam logic [5:0]  DATA_LAST         = 6'h0F;
  localparam logic [1:0]  STRAP_SETTLE      = 2'h3;

  typedef enum logic [2:0] {
    ST_PRE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } pmsc_state_type;

  // Nibble-wide media path beat
  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } pmsc_mii_type;

  typedef struct packed {
    logic       bcast_off;
    logic       reduced_pins;
    logic [2:0] addr;
  } pmsc_strap_type;

endpackage

// ---- hw/pmsc_sync.sv ----
`timescale 1ns/1ps
module pmsc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// ---- hw/pmsc_crossover.sv ----
`timescale 1ns/1ps
module pmsc_crossover (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_auto_en,
  input  wire logic i_force_crossed,
  input  wire logic i_partner_on_our_tx,
  output logic      o_crossed
);

  logic crossed_d;

  // Partner energy on our transmit pair means the cable needs crossing
  assign crossed_d = i_auto_en ? i_partner_on_our_tx       // see R15
                               : i_force_crossed;          // see R14

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_crossed <= 1'b0;
    end else begin
      o_crossed <= crossed_d;
    end
  end

endmodule

// ---- bench/pmsc_props.sv ----
`timescale 1ns/1ps
module pmsc_props (
  input wire logic                   I_CORE_CLK,
  input wire logic                   I_ARST_N,
  input wire logic                   I_MGMT_CLK,
  input wire logic                   O_MGMT_DATA,
  input wire logic                   O_MGMT_DATA_OE,
  input wire logic                   I_REDUCED_PIN_STRAP,
  input wire logic [7:0]             I_IRQ_EVENTS,
  input wire logic                   O_STATUS_CHANGE_IRQ_PIN,
  input wire logic                   I_PARTNER_ON_OUR_TX,
  input wire logic                   O_CROSSED_PAIRS,
  input wire pmsc_pkg::pmsc_mii_type I_MAC_TX,
  input wire pmsc_pkg::pmsc_mii_type I_LINE_RX,
  input wire pmsc_pkg::pmsc_mii_type O_MAC_RX,
  input wire pmsc_pkg::pmsc_mii_type O_LINE_TX,
  input wire logic                   O_SPEED_100,
  input wire logic                   O_LOOPBACK_ACTIVE
);
  // Bench clocks management at 25 core cycles; 17 driven bits on a read
  localparam int OE_LO = 420;
  localparam int OE_HI = 430;
  logic [9:0] oe_cnt_q;
  logic [2:0] live_q;
  logic       live;
  assign live = (live_q == 3'h7);
  // Strap capture and reset values settle during the first cycles
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      oe_cnt_q <= 10'h000;
      live_q   <= 3'h0;
    end else begin
      oe_cnt_q <= O_MGMT_DATA_OE ? oe_cnt_q + 10'h001 : 10'h000;
      live_q   <= live_q + {2'h0, !live};
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_mdc_high;
    I_MGMT_CLK;
  endsequence
  sequence s_loop_held;
    live && O_LOOPBACK_ACTIVE && $past(O_LOOPBACK_ACTIVE);
  endsequence
  AST_TA_LOW:
    assert property ($rose(O_MGMT_DATA_OE) |-> !O_MGMT_DATA)
    else $error("turnaround bit not low");
  AST_OE_LENGTH:
    assert property ($fell(O_MGMT_DATA_OE) |->
      oe_cnt_q >= OE_LO && oe_cnt_q <= OE_HI)
    else $error("data line driven for wrong length");
  AST_MGMT_ON_MDC:
    assert property (($changed(O_MGMT_DATA) || $changed(O_MGMT_DATA_OE))
      |-> s_mdc_high)
    else $error("data line moved outside clock high");
  AST_LOOP_PATH:
    assert property (s_loop_held |-> O_MAC_RX == $past(I_MAC_TX))
    else $error("loopback data not returned");
  AST_NORMAL_PATH:
    assert property (live && !O_LOOPBACK_ACTIVE && !$past(O_LOOPBACK_ACTIVE)
      |-> O_MAC_RX == $past(I_LINE_RX))
    else $error("receive path wrong outside loopback");
  AST_COPPER_ECHO:
    assert property (live && !(I_REDUCED_PIN_STRAP && (O_LOOPBACK_ACTIVE
      || $past(O_LOOPBACK_ACTIVE))) |-> O_LINE_TX == $past(I_MAC_TX))
    else $error("transmit not sent to copper");
  AST_COPPER_QUIET:
    assert property (live && I_REDUCED_PIN_STRAP && O_LOOPBACK_ACTIVE
      |-> O_LINE_TX == '0)
    else $error("copper not quiet in reduced-pin loopback");
  AST_IRQ_CAUSE:
    assert property ($changed(O_STATUS_CHANGE_IRQ_PIN) |-> I_MGMT_CLK
      || $past(I_IRQ_EVENTS, 2) != 8'h00 || $past(I_IRQ_EVENTS, 3) != 8'h00)
    else $error("interrupt pin moved without cause");
  AST_CROSS_CAUSE:
    assert property (live && $changed(O_CROSSED_PAIRS) |-> I_MGMT_CLK
      || $past(I_PARTNER_ON_OUR_TX, 2) != $past(I_PARTNER_ON_OUR_TX, 5))
    else $error("pair assignment moved without cause");
  AST_CFG_ON_MDC:
    assert property (live && ($changed(O_SPEED_100)
      || $changed(O_LOOPBACK_ACTIVE)) |-> s_mdc_high)
    else $error("mode outputs moved without a write");
endmodule

// ---- bench/pmsc_mgmt_ctl.sv ----
`timescale 1ns/1ps
module pmsc_mgmt_ctl (
  output logic      o_mdc,
  output logic      o_oe,
  output logic      o_d,
  input  wire logic i_line
);
  // 125 ns period stays under the 10 MHz ceiling
  localparam realtime HALF = 62.5;
  initial begin
    o_mdc = 1'b0;
    o_oe = 1'b0;
    o_d = 1'b0;
  end
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, ra,
    input logic [15:0] wd, output logic [15:0] rd, output logic ta0);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    ta0 = 1'b1;
    for (int i = 63; i >= 0; i--) begin
      // A read hands the line over from the first turnaround bit
      o_oe = !(op == pmsc_pkg::OP_READ && i < 18);
      o_d = bits[i];
      #(HALF);
      if (i == 16) ta0 = i_line;
      if (i < 16) rd[i] = i_line;
      o_mdc = 1'b1;
      #(HALF);
      o_mdc = 1'b0;
    end
    o_oe = 1'b0;
  endtask
endmodule

// ---- bench/pmsc_top_bench.sv ----
`timescale 1ns/1ps
module pmsc_top_bench;
  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   mdc, c_oe, c_d, line, d_d, d_oe;
  logic [7:0]             ev = 8'h00;
  logic                   ptx = 1'b0;
  logic [2:0]             sadr = 3'h5;
  logic                   sbc = 1'b0;
  logic                   srd = 1'b0;
  pmsc_pkg::pmsc_mii_type mtx = 5'h00;
  pmsc_pkg::pmsc_mii_type lrx = 5'h13;
  pmsc_pkg::pmsc_mii_type mrx, ltx;
  logic                   spd, loop, irq, crs, ta;
  logic                   oe_seen = 1'b0;
  logic [15:0]            rv;
  int                     error_cnt = 0;
  int                     samples_checked = 0;
  always #2.5 clk = ~clk;
  // Pull-up holds the line high whenever nobody drives it
  assign line = d_oe ? d_d : (c_oe ? c_d : 1'b1);
  always @(posedge clk) if (d_oe === 1'b1) oe_seen <= 1'b1;
  pmsc_top pmsc_top_i (
    .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_MGMT_CLK(mdc),
    .I_MGMT_DATA(line), .O_MGMT_DATA(d_d), .O_MGMT_DATA_OE(d_oe),
    .I_UNIQUE_ADDRESS_STRAPS(sadr), .I_BROADCAST_DISABLE_STRAP(sbc),
    .I_REDUCED_PIN_STRAP(srd), .I_IRQ_EVENTS(ev),
    .O_STATUS_CHANGE_IRQ_PIN(irq), .I_PARTNER_ON_OUR_TX(ptx),
    .O_CROSSED_PAIRS(crs), .I_MAC_TX(mtx), .I_LINE_RX(lrx),
    .O_MAC_RX(mrx), .O_LINE_TX(ltx), .O_SPEED_100(spd),
    .O_LOOPBACK_ACTIVE(loop));
  pmsc_mgmt_ctl pmsc_mgmt_ctl_i (
    .o_mdc(mdc), .o_oe(c_oe), .o_d(c_d), .i_line(line));
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] phy, ra);
    oe_seen = 1'b0;
    pmsc_mgmt_ctl_i.frame(pmsc_pkg::OP_READ, phy, ra, 16'h0000, rv, ta);
    tick(2);
  endtask
  task automatic wr(input logic [4:0] phy, ra, input logic [15:0] v);
    pmsc_mgmt_ctl_i.frame(pmsc_pkg::OP_WRITE, phy, ra, v, rv, ta);
    tick(2);
  endtask
  task automatic pulse(input logic [7:0] e);
    ev = e;
    tick(1);
    ev = 8'h00;
    tick(4);
  endtask
  task automatic t_reset();
    rd(5'h05, pmsc_pkg::REG_BASIC);
    check("basic", rv, pmsc_pkg::BASIC_RST);
    check("ta", 16'(ta), 16'h0000);
    check("speed", 16'(spd), 16'h0001);
    check("irq pin", 16'(irq), 16'h0001);
    ptx = 1'b1;
    tick(6);
    check("auto crossed", 16'(crs), 16'h0001);
    ptx = 1'b0;
    tick(6);
    check("auto straight", 16'(crs), 16'h0000);
  endtask
  task automatic t_addr();
    rd(5'h00, pmsc_pkg::REG_BASIC);
    check("bcast read", rv, pmsc_pkg::BASIC_RST);
    rd(5'h03, pmsc_pkg::REG_BASIC);
    check("other addr", rv, 16'hFFFF);
    check("other oe", 16'(oe_seen), 16'h0000);
    rd(5'h0D, pmsc_pkg::REG_BASIC);
    check("upper addr", rv, 16'hFFFF);
    wr(5'h02, pmsc_pkg::REG_CTRL2, 16'h6000);
    check("ignored write", 16'(crs), 16'h0000);
    rd(5'h05, 5'h05);
    check("unmapped", rv, pmsc_pkg::READ_UNMAPPED);
    wr(5'h00, pmsc_pkg::REG_CTRL1, 16'h0200);
    rd(5'h00, pmsc_pkg::REG_CTRL1);
    check("bcast off", rv, 16'hFFFF);
    rd(5'h05, pmsc_pkg::REG_CTRL1);
    check("bcast write", rv, 16'h0200);
  endtask
  task automatic t_cross();
    wr(5'h05, pmsc_pkg::REG_CTRL2, 16'h6000);
    check("forced crossed", 16'(crs), 16'h0001);
    ptx = 1'b1;
    tick(6);
    wr(5'h05, pmsc_pkg::REG_CTRL2, 16'h2000);
    check("forced straight", 16'(crs), 16'h0000);
    wr(5'h05, pmsc_pkg::REG_CTRL2, 16'h0000);
    tick(4);
    check("auto again", 16'(crs), 16'h0001);
    ptx = 1'b0;
  endtask
  task automatic t_irq();
    pulse(8'h04);
    check("masked", 16'(irq), 16'h0001);
    rd(5'h05, pmsc_pkg::REG_IRQ);
    check("flags", rv, 16'h0004);
    rd(5'h05, pmsc_pkg::REG_IRQ);
    check("cleared", rv, 16'h0000);
    wr(5'h05, pmsc_pkg::REG_IRQ, 16'h0400);
    pulse(8'h04);
    check("active low", 16'(irq), 16'h0000);
    wr(5'h05, pmsc_pkg::REG_CTRL2, 16'h0200);
    check("active high", 16'(irq), 16'h0001);
    rd(5'h05, pmsc_pkg::REG_IRQ);
    check("enable flags", rv, 16'h0404);
    check("idle high pol", 16'(irq), 16'h0000);
  endtask
  task automatic t_loop();
    mtx = 5'h1A;
    wr(5'h05, pmsc_pkg::REG_BASIC, 16'h4100);
    check("loop", 16'(loop), 16'h0001);
    check("10M", 16'(spd), 16'h0000);
    check("to mac", 16'(mrx), 16'h001A);
    check("copper", 16'(ltx), 16'h001A);
    wr(5'h05, pmsc_pkg::REG_BASIC, 16'h4000);
    check("half duplex", 16'(loop), 16'h0000);
    check("normal rx", 16'(mrx), 16'h0013);
    wr(5'h05, pmsc_pkg::REG_BASIC, 16'h5100);
    check("aneg on", 16'(loop), 16'h0000);
    wr(5'h05, pmsc_pkg::REG_BASIC, 16'h6100);
    check("loop 100", 16'(loop), 16'h0001);
    check("100M", 16'(spd), 16'h0001);
  endtask
  // Second reset with new straps: address 2, no broadcast, reduced pins
  task automatic t_strap();
    arst_n = 1'b0;
    sadr = 3'h2;
    sbc = 1'b1;
    srd = 1'b1;
    tick(3);
    arst_n = 1'b1;
    tick(8);
    check("reset pin", 16'(irq), 16'h0001);
    rd(5'h00, pmsc_pkg::REG_BASIC);
    check("strap bcast off", rv, 16'hFFFF);
    rd(5'h02, pmsc_pkg::REG_BASIC);
    check("strap addr", rv, pmsc_pkg::BASIC_RST);
    wr(5'h02, pmsc_pkg::REG_BASIC, 16'h4100);
    check("rpc to mac", 16'(mrx), 16'h001A);
    check("rpc copper", 16'(ltx), 16'h0000);
  endtask
  initial begin
    tick(12);
    arst_n = 1'b1;
    tick(8);
    t_reset();
    t_addr();
    t_cross();
    t_irq();
    t_loop();
    t_strap();
    end_sim();
  end
  initial begin
    #450000;
    error_cnt++;
    $display("wrong value run expected done seen hang");
    end_sim();
  end
endmodule
bind pmsc_top pmsc_props pmsc_props_i (
  .I_CORE_CLK, .I_ARST_N, .I_MGMT_CLK, .O_MGMT_DATA, .O_MGMT_DATA_OE,
  .I_REDUCED_PIN_STRAP, .I_IRQ_EVENTS, .O_STATUS_CHANGE_IRQ_PIN,
  .I_PARTNER_ON_OUR_TX, .O_CROSSED_PAIRS, .I_MAC_TX, .I_LINE_RX,
  .O_MAC_RX, .O_LINE_TX, .O_SPEED_100, .O_LOOPBACK_ACTIVE);
